// ---- bench/dmfe_ctrl_model.sv ----
`default_nettype none

module dmfe_ctrl_model (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic fast,
    input wire logic [1:0] ref_sel,
    input wire logic data_in,
    input wire logic data_in_inv,
    output logic dev_clk,
    output logic ref_pin,
    output logic v_bit,
    output logic c_bit,
    output logic inv_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    int half;
    initial begin
        dev_clk = 1'b0;
        v_bit = 1'b0;
        c_bit = 1'b0;
        inv_ok = 1'b0;
    end
    assign half = fast ? 61 : 122;
    // The clock stops low when run drops, to model a lost controller clock.
    always @(negedge ref_clk) begin
        if (!run) begin
            cnt <= 0;
            dev_clk <= 1'b0;
        end else if (cnt >= half - 1) begin
            cnt <= 0;
            dev_clk <= !dev_clk;
        end else begin
            cnt <= cnt + 1;
        end
        if (run && cnt == half - 8) begin
            if (dev_clk) begin
                v_bit <= data_in;
            end else begin
                c_bit <= data_in;
            end
            inv_ok <= (data_in_inv === !data_in);
        end
    end
    always_comb begin
        case (ref_sel)
            2'h0: ref_pin = 1'b0;
            2'h1: ref_pin = dev_clk;
            2'h2: ref_pin = !dev_clk;
            default: ref_pin = 1'b1;
        endcase
    end
endmodule : dmfe_ctrl_model

`default_nettype wire

// ---- bench/dmfe_front_end_asserts.sv ----
`default_nettype none

module dmfe_front_end_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic dev_clk_pin,
    input wire logic supply_ok_pin,
    input wire logic gain_select_pin,
    input wire logic reference_mode_pin,
    input wire logic voltage_bitstream,
    input wire logic current_bitstream,
    input wire logic conv_phase1,
    input wire logic conv_phase2,
    input wire logic chop_voltage,
    input wire logic chop_current_p,
    input wire logic chop_current_n,
    input wire logic amp32_sel,
    input wire logic [1:0] ref_tc_mode,
    input wire logic prescale_hi,
    input wire logic voltage_channel_en,
    input wire logic por_active,
    input wire logic muxed_bitstream_out,
    input wire logic muxed_bitstream_out_inv
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    inv_pair_a: assert property (muxed_bitstream_out_inv != muxed_bitstream_out)
        else $error("inverted output equals direct output");
    phase_excl_a: assert property (!(conv_phase1 && conv_phase2))
        else $error("conversion phases overlap");
    chop_copy_a: assert property (chop_current_p == chop_voltage)
        else $error("current chopper differs from voltage chopper");
    hold_entry_a: assert property (!supply_ok_pin [*4] |-> por_active)
        else $error("low supply did not hold the block");
    hold_quiet_a: assert property (por_active [*3] |-> !voltage_channel_en && !chop_voltage)
        else $error("activity while held");
    ph2_off_a: assert property ((dev_clk_pin && voltage_channel_en) [*8] |-> !conv_phase2)
        else $error("second phase active in high clock half");
    ph1_off_a: assert property ((!dev_clk_pin && voltage_channel_en) [*8] |-> !conv_phase1)
        else $error("first phase active in low clock half");
    gain_hi_a: assert property ((voltage_channel_en && gain_select_pin) [*5] |-> amp32_sel)
        else $error("high gain pin did not select x32");
    gain_lo_a: assert property ((voltage_channel_en && !gain_select_pin) [*5] |-> !amp32_sel)
        else $error("low gain pin did not select x8");
    cover property ($rose(voltage_channel_en));
    cover property ($rose(prescale_hi));
    cover property ($rose(chop_voltage));
endmodule : dmfe_front_end_asserts

`default_nettype wire

// ---- bench/dmfe_front_end_test.sv ----
`default_nettype none

module dmfe_front_end_test
    import dmfe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 60000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic supply_ok_pin = 1'b1;
    logic gain_select_pin = 1'b0;
    logic voltage_bitstream = 1'b0;
    logic current_bitstream = 1'b0;
    logic run = 1'b1;
    logic fast = 1'b0;
    logic [1:0] ref_sel = 2'h0;
    logic dev_clk_pin, reference_mode_pin, v_bit, c_bit, inv_ok;
    logic conv_phase1, conv_phase2, chop_voltage, chop_current_p, chop_current_n;
    logic amp32_sel, prescale_hi, voltage_channel_en, por_active;
    logic muxed_bitstream_out, muxed_bitstream_out_inv;
    logic [1:0] ref_tc_mode;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    always #2 ref_clk = !ref_clk;

    dmfe_front_end u_dmfe_front_end (.*);
    dmfe_ctrl_model u_dmfe_ctrl_model (.ref_clk(ref_clk), .run(run), .fast(fast),
        .ref_sel(ref_sel), .data_in(muxed_bitstream_out),
        .data_in_inv(muxed_bitstream_out_inv), .dev_clk(dev_clk_pin),
        .ref_pin(reference_mode_pin), .v_bit(v_bit), .c_bit(c_bit), .inv_ok(inv_ok));

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic rises(int n);
        repeat (n) @(posedge dev_clk_pin);
        @(negedge ref_clk);
    endtask : rises

    task automatic wait_run;
        int i;
        for (i = 0; i < 3000 && voltage_channel_en !== 1'b1; i++) @(negedge ref_clk);
        check("venable", 8'(voltage_channel_en), 8'h01);
    endtask : wait_run

    task automatic t_reset;
        repeat (10) @(negedge ref_clk);
        check("out", 8'(muxed_bitstream_out), 8'h00);
        check("out_inv", 8'(muxed_bitstream_out_inv), 8'h01);
        check("por", 8'(por_active), 8'h01);
        rst = 1'b0;
        wait_run();
        $display("reset test done");
    endtask : t_reset

    task automatic t_mux;
        int k;
        for (k = 0; k < 4; k++) begin
            @(negedge dev_clk_pin);
            repeat (20) @(negedge ref_clk);
            voltage_bitstream = k[1];
            current_bitstream = k[0];
            rises(2);
            check("v_bit", 8'(v_bit), 8'(k[1]));
            check("c_bit", 8'(c_bit), 8'(k[0]));
            check("inv_ok", 8'(inv_ok), 8'h01);
        end
        $display("mux test done");
    endtask : t_mux

    task automatic t_phase;
        @(posedge dev_clk_pin);
        repeat (3) @(negedge ref_clk);
        check("phase1_guard", 8'(conv_phase1), 8'h00);
        check("phase2_off", 8'(conv_phase2), 8'h00);
        repeat (20) @(negedge ref_clk);
        check("phase1", 8'(conv_phase1), 8'h01);
        check("phase2_low", 8'(conv_phase2), 8'h00);
        @(negedge dev_clk_pin);
        repeat (3) @(negedge ref_clk);
        check("phase2_guard", 8'(conv_phase2), 8'h00);
        check("phase1_off", 8'(conv_phase1), 8'h00);
        repeat (20) @(negedge ref_clk);
        check("phase2", 8'(conv_phase2), 8'h01);
        check("phase1_low", 8'(conv_phase1), 8'h00);
        $display("phase test done");
    endtask : t_phase

    task automatic t_gain;
        int g;
        for (g = 1; g >= 0; g--) begin
            gain_select_pin = g[0];
            repeat (6) @(negedge ref_clk);
            check("amp32", 8'(amp32_sel), 8'(g[0]));
        end
        $display("gain test done");
    endtask : t_gain

    task automatic t_ref;
        int m;
        for (m = 0; m < 4; m++) begin
            ref_sel = m[1:0];
            rises(3);
            check("ref_mode", 8'(ref_tc_mode), 8'(m));
        end
        $display("reference test done");
    endtask : t_ref

    task automatic chop_gap(output int n);
        logic c0;
        logic d0;
        int i;
        n = 0;
        c0 = chop_voltage;
        d0 = dev_clk_pin;
        for (i = 0; i < 20000 && chop_voltage === c0; i++) begin
            @(negedge ref_clk);
            if (dev_clk_pin && !d0) n++;
            d0 = dev_clk_pin;
        end
    endtask : chop_gap

    task automatic t_chop;
        int n;
        chop_gap(n);
        chop_gap(n);
        check("chop_rises", 8'(n), 8'(CHOP_DIV));
        check("chop_n", 8'(chop_current_n), 8'(!chop_voltage));
        $display("chopper test done");
    endtask : t_chop

    task automatic t_fast;
        fast = 1'b1;
        rises(6);
        check("prescale", 8'(prescale_hi), 8'h01);
        t_mux();
        fast = 1'b0;
        rises(6);
        check("prescale", 8'(prescale_hi), 8'h00);
        $display("rate test done");
    endtask : t_fast

    task automatic t_por;
        supply_ok_pin = 1'b0;
        repeat (8) @(negedge ref_clk);
        check("por", 8'(por_active), 8'h01);
        check("venable", 8'(voltage_channel_en), 8'h00);
        check("out", 8'(muxed_bitstream_out), 8'h00);
        supply_ok_pin = 1'b1;
        wait_run();
        check("por", 8'(por_active), 8'h00);
        $display("supply test done");
    endtask : t_por

    task automatic t_loss;
        run = 1'b0;
        repeat (600) @(negedge ref_clk);
        check("venable", 8'(voltage_channel_en), 8'h00);
        check("out_inv", 8'(muxed_bitstream_out_inv), 8'h01);
        run = 1'b1;
        wait_run();
        $display("clock loss test done");
    endtask : t_loss

    initial begin
        t_reset();
        t_mux();
        t_phase();
        t_gain();
        t_ref();
        t_chop();
        t_fast();
        t_por();
        t_loss();
        t_mux();
        finish_test();
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            finish_test();
        end
    end
endmodule : dmfe_front_end_test

bind dmfe_front_end dmfe_front_end_asserts u_dmfe_front_end_asserts (.*);

`default_nettype wire

// ---- inc/dmfe_pkg.sv ----
`default_nettype none

package dmfe_pkg;

    // Clock rates in kHz.
    localparam int unsigned REF_CLK_KHZ = 250000;
    localparam int unsigned DEV_CLK_LO_KHZ = 1024;
    localparam int unsigned DEV_CLK_HI_KHZ = 2048;

    localparam int unsigned CNT_W = 10;

    // Device clock periods in reference clock cycles.
    localparam logic [CNT_W-1:0] PERIOD_LO_CYC = CNT_W'(REF_CLK_KHZ / DEV_CLK_LO_KHZ);
    localparam logic [CNT_W-1:0] PERIOD_HI_CYC = CNT_W'(REF_CLK_KHZ / DEV_CLK_HI_KHZ);
    localparam logic [CNT_W-1:0] PERIOD_SPLIT_CYC =
        CNT_W'((REF_CLK_KHZ / DEV_CLK_LO_KHZ + REF_CLK_KHZ / DEV_CLK_HI_KHZ) / 2);
    localparam logic [CNT_W-1:0] CLK_LOSS_CYC = CNT_W'(2 * (REF_CLK_KHZ / DEV_CLK_LO_KHZ));

    // Guard between the two conversion phases, a least time rounded up.
    localparam int unsigned NOV_NS = 20;
    localparam logic [CNT_W-1:0] NOV_CYC = CNT_W'((NOV_NS * REF_CLK_KHZ + 999999) / 1000000);

    // Device clock rising edges per chopper half period.
    localparam logic [4:0] CHOP_DIV = 5'h10;

    // Rising edges seen before the link is considered running.
    localparam logic [1:0] MEASURE_EDGES = 2'h2;

    // Reset values.
    localparam logic OUT_RST = 1'b0;
    localparam logic OUT_INV_RST = 1'b1;
    localparam logic CLK_OUT_RST = 1'b0;

    // Positions in the synchroniser vector.
    localparam int unsigned SY_DCLK = 0;
    localparam int unsigned SY_SUPPLY = 1;
    localparam int unsigned SY_GAIN = 2;
    localparam int unsigned SY_REF = 3;
    localparam int unsigned SY_BSV = 4;
    localparam int unsigned SY_BSC = 5;
    localparam int unsigned SY_W = 6;

    // Positions in the internal clock vector.
    localparam int unsigned CK_PH1 = 0;
    localparam int unsigned CK_PH2 = 1;
    localparam int unsigned CK_CHV = 2;
    localparam int unsigned CK_CHIP = 3;
    localparam int unsigned CK_CHIN = 4;
    localparam int unsigned CK_N = 5;

    localparam logic AMP_X8 = 1'b0;
    localparam logic AMP_X32 = 1'b1;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_MEASURE = 3'b010,
        ST_RUN = 3'b100
    } dmfe_state_t;

    typedef enum logic [1:0] {
        REF_TC100 = 2'h0,
        REF_TC170 = 2'h1,
        REF_TC125 = 2'h2,
        REF_TC190 = 2'h3
    } dmfe_ref_mode_t;

endpackage : dmfe_pkg

`default_nettype wire

// ---- rtl/dmfe_front_end.sv ----
`default_nettype none

module dmfe_front_end
    import dmfe_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic dev_clk_pin,
    input wire logic supply_ok_pin,
    input wire logic gain_select_pin,
    input wire logic reference_mode_pin,
    input wire logic voltage_bitstream,
    input wire logic current_bitstream,
    output logic conv_phase1,
    output logic conv_phase2,
    output logic chop_voltage,
    output logic chop_current_p,
    output logic chop_current_n,
    output logic amp32_sel,
    output logic [1:0] ref_tc_mode,
    output logic prescale_hi,
    output logic voltage_channel_en,
    output logic por_active,
    output logic muxed_bitstream_out,
    output logic muxed_bitstream_out_inv
);

    // Maps the levels seen in the high and the low clock phase to a reference mode.
    function automatic dmfe_ref_mode_t decode_ref_mode(input logic in_high, input logic in_low);
        dmfe_ref_mode_t m;
        m = REF_TC100;
        case ({in_high, in_low})
            2'b00: m = REF_TC100;
            2'b10: m = REF_TC170;
            2'b01: m = REF_TC125;
            2'b11: m = REF_TC190;
            default: m = REF_TC100;
        endcase
        return m;
    endfunction : decode_ref_mode

    logic [SY_W-1:0] pins_s;

    // Pins are asynchronous to ref_clk and pass two flops first.
    dmfe_sync #(.W(SY_W)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({current_bitstream, voltage_bitstream, reference_mode_pin,
                   gain_select_pin, supply_ok_pin, dev_clk_pin}),
        .sync_out(pins_s)
    );

    logic dclk_s;
    logic por_hold;
    logic dclk_q;
    logic dclk_d;
    logic rise;
    logic fall;

    assign dclk_s = pins_s[SY_DCLK];
    assign por_hold = ~pins_s[SY_SUPPLY];
    assign rise = dclk_s & ~dclk_q;
    assign fall = ~dclk_s & dclk_q;

    // Device clock tracking: edge memory, period and phase counters.
    logic [CNT_W-1:0] period_cnt_q;
    logic [CNT_W-1:0] period_cnt_d;
    logic [CNT_W-1:0] period_q;
    logic [CNT_W-1:0] period_d;
    logic [CNT_W-1:0] phase_cnt_q;
    logic [CNT_W-1:0] phase_cnt_d;
    logic clk_lost;

    always_comb begin
        dclk_d = dclk_s;
        period_cnt_d = period_cnt_q;
        period_d = period_q;
        phase_cnt_d = phase_cnt_q;
        clk_lost = (period_cnt_q >= CLK_LOSS_CYC);
        if (por_hold) begin
            dclk_d = 1'b0;
            period_cnt_d = '0;
            period_d = '0;
            phase_cnt_d = '0;
        end else begin
            if (rise) begin
                period_d = period_cnt_q;
                period_cnt_d = '0;
            end else if (!clk_lost) begin
                period_cnt_d = period_cnt_q + CNT_W'(1);
            end
            if (rise || fall) begin
                phase_cnt_d = '0;
            end else if (phase_cnt_q != {CNT_W{1'b1}}) begin
                phase_cnt_d = phase_cnt_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dclk_q <= 1'b0;
            period_cnt_q <= '0;
            period_q <= '0;
            phase_cnt_q <= '0;
        end else begin
            dclk_q <= dclk_d;
            period_cnt_q <= period_cnt_d;
            period_q <= period_d;
            phase_cnt_q <= phase_cnt_d;
        end
    end

    // Link state: held in reset, measuring the clock, or running.
    dmfe_state_t state_q;
    dmfe_state_t state_d;
    logic [1:0] edges_q;
    logic [1:0] edges_d;
    logic running;

    assign running = (state_q == ST_RUN);

    always_comb begin
        state_d = state_q;
        edges_d = edges_q;
        case (state_q)
            ST_HOLD: begin
                edges_d = '0;
                if (!por_hold) begin
                    state_d = ST_MEASURE;
                end
            end
            ST_MEASURE: begin
                if (rise) begin
                    edges_d = edges_q + 2'h1;
                    if (edges_q + 2'h1 == MEASURE_EDGES) begin
                        state_d = ST_RUN;
                    end
                end
                if (clk_lost) begin
                    edges_d = '0;
                end
            end
            ST_RUN: begin
                // A stopped device clock returns the block to measuring.
                if (clk_lost) begin
                    state_d = ST_MEASURE;
                    edges_d = '0;
                end
            end
            default: begin
                state_d = ST_HOLD;
                edges_d = '0;
            end
        endcase
        if (por_hold) begin
            state_d = ST_HOLD;
            edges_d = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_HOLD;
            edges_q <= '0;
        end else begin
            state_q <= state_d;
            edges_q <= edges_d;
        end
    end

    // Mode decoding from the two mode pins.
    logic amp32_q;
    logic amp32_d;
    logic ref_hi_q;
    logic ref_hi_d;
    logic ref_lo_q;
    logic ref_lo_d;
    dmfe_ref_mode_t ref_mode_q;
    dmfe_ref_mode_t ref_mode_d;
    logic presc_q;
    logic presc_d;
    logic ven_q;
    logic ven_d;
    logic mid_phase;

    // The mode pin is sampled a guard time after each edge, clear of the transition.
    assign mid_phase = (phase_cnt_q == NOV_CYC);

    always_comb begin
        amp32_d = amp32_q;
        ref_hi_d = ref_hi_q;
        ref_lo_d = ref_lo_q;
        ref_mode_d = ref_mode_q;
        presc_d = presc_q;
        ven_d = running;
        if (running) begin
            amp32_d = pins_s[SY_GAIN] ? AMP_X32 : AMP_X8;
            if (mid_phase && dclk_s) begin
                ref_hi_d = pins_s[SY_REF];
            end
            if (mid_phase && !dclk_s) begin
                ref_lo_d = pins_s[SY_REF];
            end
            if (rise) begin
                ref_mode_d = decode_ref_mode(ref_hi_q, ref_lo_q);
                presc_d = (period_q < PERIOD_SPLIT_CYC);
            end
        end
        if (por_hold) begin
            amp32_d = AMP_X8;
            ref_hi_d = 1'b0;
            ref_lo_d = 1'b0;
            ref_mode_d = REF_TC100;
            presc_d = 1'b0;
            ven_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            amp32_q <= AMP_X8;
            ref_hi_q <= 1'b0;
            ref_lo_q <= 1'b0;
            ref_mode_q <= REF_TC100;
            presc_q <= 1'b0;
            ven_q <= 1'b0;
        end else begin
            amp32_q <= amp32_d;
            ref_hi_q <= ref_hi_d;
            ref_lo_q <= ref_lo_d;
            ref_mode_q <= ref_mode_d;
            presc_q <= presc_d;
            ven_q <= ven_d;
        end
    end

    // Five analog clocks, all derived from the device clock.
    logic [CK_N-1:0] clks_q;
    logic [CK_N-1:0] clks_d;
    logic [4:0] chop_cnt_q;
    logic [4:0] chop_cnt_d;
    logic chop_q;
    logic chop_d;

    always_comb begin
        chop_cnt_d = chop_cnt_q;
        chop_d = chop_q;
        clks_d = {CK_N{CLK_OUT_RST}};
        if (running) begin
            if (rise) begin
                if (chop_cnt_q == CHOP_DIV - 5'h01) begin
                    chop_cnt_d = '0;
                    chop_d = ~chop_q;
                end else begin
                    chop_cnt_d = chop_cnt_q + 5'h01;
                end
            end
            // Phases never overlap: each waits a guard time after its edge.
            // The count still holds the old phase on the edge cycle, so the edge is excluded.
            clks_d[CK_PH1] = dclk_s && !rise && (phase_cnt_q >= NOV_CYC);
            clks_d[CK_PH2] = !dclk_s && !fall && (phase_cnt_q >= NOV_CYC);
            clks_d[CK_CHV] = chop_d;
            clks_d[CK_CHIP] = chop_d;
            clks_d[CK_CHIN] = ~chop_d;
        end else begin
            chop_cnt_d = '0;
            chop_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chop_cnt_q <= '0;
            chop_q <= 1'b0;
            clks_q <= {CK_N{CLK_OUT_RST}};
        end else begin
            chop_cnt_q <= chop_cnt_d;
            chop_q <= chop_d;
            clks_q <= clks_d;
        end
    end

    // Bitstream capture on the device clock and time multiplexing onto one pair.
    logic bsv_q;
    logic bsv_d;
    logic bsc_q;
    logic bsc_d;
    logic out_q;
    logic out_d;
    logic out_inv_q;
    logic out_inv_d;

    always_comb begin
        bsv_d = bsv_q;
        bsc_d = bsc_q;
        out_d = OUT_RST;
        if (running) begin
            if (rise) begin
                bsv_d = pins_s[SY_BSV];
                bsc_d = pins_s[SY_BSC];
            end
            out_d = dclk_s ? bsv_d : bsc_d;
        end
        if (por_hold) begin
            bsv_d = 1'b0;
            bsc_d = 1'b0;
        end
        out_inv_d = ~out_d;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bsv_q <= 1'b0;
            bsc_q <= 1'b0;
            out_q <= OUT_RST;
            out_inv_q <= OUT_INV_RST;
        end else begin
            bsv_q <= bsv_d;
            bsc_q <= bsc_d;
            out_q <= out_d;
            out_inv_q <= out_inv_d;
        end
    end

    assign conv_phase1 = clks_q[CK_PH1];
    assign conv_phase2 = clks_q[CK_PH2];
    assign chop_voltage = clks_q[CK_CHV];
    assign chop_current_p = clks_q[CK_CHIP];
    assign chop_current_n = clks_q[CK_CHIN];
    assign amp32_sel = amp32_q;
    assign ref_tc_mode = ref_mode_q;
    assign prescale_hi = presc_q;
    assign voltage_channel_en = ven_q;
    assign por_active = (state_q == ST_HOLD);
    assign muxed_bitstream_out = out_q;
    assign muxed_bitstream_out_inv = out_inv_q;

endmodule : dmfe_front_end

`default_nettype wire

// ---- rtl/dmfe_sync.sv ----
`default_nettype none

module dmfe_sync
    import dmfe_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Each bit gets its own pair of flops; the first is read only by the second.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_comb begin
                meta_d[g] = async_in[g];
                sync_d[g] = meta_q[g];
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : dmfe_sync

`default_nettype wire
